// file: core/rotate_round_pkg.sv
// Package with the constants shared by the rotate and round unit
package rotate_round_pkg;

	// Default accumulator width in bits
	localparam int ACC_W = 24;
	// Width of the repeat count operand
	localparam int COUNT_W = 4;

	// Register port address width
	localparam int ADDR_W = 4;
	// Register map, word addresses on the plain register port
	localparam logic [3:0] ADDR_ACC0 = 4'h0;
	localparam logic [3:0] ADDR_ACC1 = 4'h1;
	localparam logic [3:0] ADDR_ACC2 = 4'h2;
	localparam logic [3:0] ADDR_ACC3 = 4'h3;
	localparam logic [3:0] ADDR_FLAGS = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;

	// Flag register field positions
	localparam int FLAG_C_POS = 0;
	localparam int FLAG_O_POS = 1;
	localparam int FLAG_S_POS = 2;
	localparam int FLAG_Z_POS = 3;
	// Status register field positions
	localparam int STAT_BUSY_POS = 0;
	localparam int STAT_BYTES_POS = 4;

	// Values after reset
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [2:0] BYTES_RESET = 3'h0;

	// Code length of each instruction in bytes
	localparam logic [2:0] BYTES_ROT_PLAIN = 3'h1;
	localparam logic [2:0] BYTES_ROT_COUNT = 3'h2;
	localparam logic [2:0] BYTES_ROUND = 3'h7;
	localparam logic [2:0] BYTES_SET_CARRY = 3'h1;

	// Index of the accumulator that rounding works on
	localparam logic [1:0] ROUND_ACC = 2'h0;

	// Instruction codes on the instruction port
	typedef enum logic [1:0] {
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_ROUND,
		OP_FORCE_CARRY_ONE
	} op_t;

endpackage

// file: core/round_divider.sv
// Restoring unsigned divider used by the rounding instruction
`timescale 1ns/1ps
module round_divider #(
	parameter int W = 24
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [W-1:0] dividend,
	input wire logic [W-1:0] divisor,
	output logic done,
	output logic [W-1:0] quotient,
	output logic [W-1:0] remainder
);
	localparam int CW = $clog2(W + 1);
	localparam logic [CW-1:0] STEPS = CW'(W);

	// Partial remainder, one bit wider for the compare
	logic [W:0] rem;
	// Quotient shift register, starts holding the dividend
	logic [W-1:0] quo;
	// Remaining quotient bits
	logic [CW-1:0] cnt;
	// Divisor held for the whole division
	logic [W-1:0] div;

	// One restoring step
	wire [W:0] shifted = {rem[W-1:0], quo[W-1]};
	wire fits = shifted >= {1'b0, div};
	wire [W:0] next_rem = fits ? shifted - {1'b0, div} : shifted;
	wire [W-1:0] next_quo = {quo[W-2:0], fits};

	// One quotient bit per cycle, W cycles in all
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rem <= '0;
			quo <= '0;
			div <= '0;
			cnt <= '0;
			done <= 1'b0;
		end else if (start) begin
			rem <= '0;
			quo <= dividend;
			div <= divisor;
			cnt <= STEPS;
			done <= 1'b0;
		end else if (cnt != '0) begin
			rem <= next_rem;
			quo <= next_quo;
			cnt <= cnt - CW'(1);
			done <= (cnt == CW'(1));
		end else begin
			done <= 1'b0;
		end
	end

	// Results are stable once done has pulsed
	assign quotient = quo;
	assign remainder = rem[W-1:0];
endmodule

// file: core/accumulator_rotate_round_unit.sv
// Rotate through carry, rounding and set carry unit on the general accumulators
//
// Summary of operation
// - Rotates pick one of four accumulators, optional count
// - Left step: carry into LSB, MSB to carry
// - Counted left rotate repeats the single step
// - Left rotate sets C O S Z from last step
// - Right step: carry into MSB, LSB to carry
// - Counted right rotate repeats the single step
// - Right rotate sets C O S Z from last step
// - Rotate: one byte, one cycle; counted: two, 1+count
// - Rounding uses first accumulator, seven code bytes
// - Round magnitude down below half, up at half or more
// - Set carry forces C one, O zero, one cycle
`timescale 1ns/1ps
module accumulator_rotate_round_unit #(
	parameter int ACC_W = rotate_round_pkg::ACC_W
) (
	input wire logic clk,
	input wire logic rst_n,
	// Instruction port from the decoder
	input wire logic op_valid,
	input wire logic [1:0] op_code,
	input wire logic [1:0] op_acc,
	input wire logic op_has_count,
	input wire logic [rotate_round_pkg::COUNT_W-1:0] op_count,
	input wire logic [ACC_W-1:0] op_divisor,
	output logic op_ready,
	output logic op_done,
	output logic [2:0] op_bytes,
	// Register port
	input wire logic [rotate_round_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ACC_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [ACC_W-1:0] reg_rdata,
	// Flag register
	output logic flag_carry,
	output logic flag_overflow,
	output logic flag_sign,
	output logic flag_zero
);
	localparam int CNT_W = rotate_round_pkg::COUNT_W;

	// Engine states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ROTATE,
		ST_ROUND_DIV,
		ST_ROUND_FIX
	} state_t;

	// Current engine state
	state_t state;
	// Next engine state, also used to time op_ready
	state_t next_state;

	// The four general accumulators
	logic [ACC_W-1:0] general_accumulator [4];

	// Accumulator and direction held for a counted rotate
	logic [1:0] run_acc;
	logic run_right;
	// Steps still to run
	logic [CNT_W-1:0] steps_left;
	// Divisor and sign held during rounding
	logic [ACC_W-1:0] run_div;
	logic run_neg;

	// Decode of the incoming instruction
	wire take = op_valid && op_ready;
	wire is_rot_left = op_code == 2'(rotate_round_pkg::OP_ROTATE_LEFT_CARRY);
	wire is_rot_right = op_code == 2'(rotate_round_pkg::OP_ROTATE_RIGHT_CARRY);
	wire is_round = op_code == 2'(rotate_round_pkg::OP_ROUND);
	wire is_force_carry = op_code == 2'(rotate_round_pkg::OP_FORCE_CARRY_ONE);
	wire is_rotate = is_rot_left || is_rot_right;
	// A missing count means exactly one step
	wire take_single = take && is_rotate && !op_has_count;
	// A count of zero only spends the fetch cycle
	wire take_counted = take && is_rotate && op_has_count && (op_count != '0);
	wire take_empty = take && is_rotate && op_has_count && (op_count == '0);
	// Round always works on the first accumulator, op_acc is unused
	wire take_round = take && is_round;
	// Set carry is a single-cycle flag update
	wire take_force = take && is_force_carry;

	// Step source: the new instruction, or the held one while running
	wire in_rotate = state == ST_ROTATE;
	wire [1:0] step_acc = in_rotate ? run_acc : op_acc;
	wire step_right = in_rotate ? run_right : is_rot_right;
	wire [ACC_W-1:0] step_src = general_accumulator[step_acc];

	// Left step: old carry into bit 0, top bit out to carry
	wire [ACC_W-1:0] left_res = {step_src[ACC_W-2:0], flag_carry};
	wire left_carry = step_src[ACC_W-1];
	// Right step: old carry into the top bit, bit 0 out to carry
	wire [ACC_W-1:0] right_res = {flag_carry, step_src[ACC_W-1:1]};
	wire right_carry = step_src[0];
	wire [ACC_W-1:0] step_res = step_right ? right_res : left_res;
	wire step_carry = step_right ? right_carry : left_carry;
	// Overflow marks a change of sign across the step
	wire step_ovf = step_src[ACC_W-1] ^ step_res[ACC_W-1];
	wire step_sign = step_res[ACC_W-1];
	wire step_zero = step_res == '0;
	// A step is applied on a single rotate or on each running cycle
	wire do_step = take_single || in_rotate;
	wire last_step = in_rotate && (steps_left == CNT_W'(1));

	// Rounding on the magnitude of the first accumulator
	wire [ACC_W-1:0] round_src = general_accumulator[rotate_round_pkg::ROUND_ACC];
	wire round_src_neg = round_src[ACC_W-1];
	wire [ACC_W-1:0] round_mag = round_src_neg ? ACC_W'(-round_src) : round_src;
	// A zero divisor leaves the value as it is
	wire round_trivial = op_divisor == '0;
	wire div_start = take_round && !round_trivial;
	wire div_done;
	wire [ACC_W-1:0] div_quo;
	wire [ACC_W-1:0] div_rem;

	// Quotient back to a multiple of the division
	wire [2*ACC_W-1:0] round_prod = div_quo * run_div;
	wire [ACC_W-1:0] round_floor = round_prod[ACC_W-1:0];
	// Twice the remainder against the division decides the direction
	wire round_up = {div_rem, 1'b0} >= {1'b0, run_div};
	wire [ACC_W-1:0] round_mag_new = round_up ? round_floor + run_div : round_floor;
	wire [ACC_W-1:0] round_res = run_neg ? ACC_W'(-round_mag_new) : round_mag_new;
	wire round_write = state == ST_ROUND_FIX;

	// Register port decode
	// Status is read-only, so it has no write decode
	wire bus_idle = state == ST_IDLE;
	wire sel_acc = reg_addr <= rotate_round_pkg::ADDR_ACC3;
	wire sel_flags = reg_addr == rotate_round_pkg::ADDR_FLAGS;
	wire sel_status = reg_addr == rotate_round_pkg::ADDR_STATUS;
	// Writes are held off while an instruction owns the datapath
	wire wr_acc = reg_write && sel_acc && bus_idle && !take;
	wire wr_flags = reg_write && sel_flags && bus_idle && !take;
	wire [1:0] wr_idx = reg_addr[1:0];

	// Read data selection, unmapped addresses read zero
	// Accumulator reads go through the same index as writes
	wire [ACC_W-1:0] flags_word = ACC_W'({flag_zero, flag_sign, flag_overflow, flag_carry});
	// Status: busy and the last code length, placed at their package positions
	wire [ACC_W-1:0] status_word = (ACC_W'(op_bytes) << rotate_round_pkg::STAT_BYTES_POS) |
		(ACC_W'(!op_ready) << rotate_round_pkg::STAT_BUSY_POS);
	wire [ACC_W-1:0] next_rdata = sel_acc ? general_accumulator[wr_idx] :
		sel_flags ? flags_word :
		sel_status ? status_word : '0;

	// Code length of the instruction being taken
	wire [2:0] next_bytes = is_round ? rotate_round_pkg::BYTES_ROUND :
		is_force_carry ? rotate_round_pkg::BYTES_SET_CARRY :
		op_has_count ? rotate_round_pkg::BYTES_ROT_COUNT :
		rotate_round_pkg::BYTES_ROT_PLAIN;

	// Instruction finishes in this cycle
	wire finish = take_single || take_empty || take_force ||
		(take_round && round_trivial) || last_step || round_write;

	// Divider for the rounding subroutine
	// The divider latches the divisor itself at start
	round_divider #(
		.W(ACC_W)
	) u_divider (
		.clk(clk),
		.rst_n(rst_n),
		.start(div_start),
		.dividend(round_mag),
		.divisor(op_divisor),
		.done(div_done),
		.quotient(div_quo),
		.remainder(div_rem)
	);

	// Next state of the engine
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				// Single-cycle instructions finish without leaving idle
				if (take_counted) begin
					next_state = ST_ROTATE;
				end else if (div_start) begin
					next_state = ST_ROUND_DIV;
				end
			end
			ST_ROTATE: begin
				// Leave after the step that uses up the count
				if (last_step) begin
					next_state = ST_IDLE;
				end
			end
			ST_ROUND_DIV: begin
				// One quotient bit per cycle until the divider reports done
				if (div_done) begin
					next_state = ST_ROUND_FIX;
				end
			end
			ST_ROUND_FIX: begin
				// Rounded value is written on the edge that leaves
				next_state = ST_IDLE;
			end
			default: begin
				// Unused encoding falls back to idle
				next_state = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Operands held for multi-cycle instructions
	// Sign is caught at take; the divider only sees the magnitude
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_acc <= 2'h0;
			run_right <= 1'b0;
			run_div <= '0;
			run_neg <= 1'b0;
		end else if (take) begin
			run_acc <= op_acc;
			run_right <= is_rot_right;
			run_div <= op_divisor;
			run_neg <= round_src_neg;
		end
	end

	// Step counter, loaded with the count and run down to one
	// Running down to one makes last_step a plain compare
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			steps_left <= '0;
		end else if (take_counted) begin
			steps_left <= op_count;
		end else if (in_rotate) begin
			steps_left <= steps_left - CNT_W'(1);
		end
	end

	// Accumulators: engine results win over register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				general_accumulator[i] <= '0;
			end
		end else if (do_step) begin
			// Each cycle of a counted rotate is one full step
			general_accumulator[step_acc] <= step_res;
		end else if (round_write) begin
			// Rounded result back into the first accumulator
			general_accumulator[rotate_round_pkg::ROUND_ACC] <= round_res;
		end else if (wr_acc) begin
			// Software load, only reached while idle and not taking
			general_accumulator[wr_idx] <= reg_wdata;
		end
	end

	// Carry follows every step, so the final carry is the last step's
	// Steps and set carry never meet, only one instruction runs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_carry <= rotate_round_pkg::FLAG_RESET;
		end else if (do_step) begin
			flag_carry <= step_carry;
		end else if (take_force) begin
			flag_carry <= 1'b1;
		end else if (wr_flags) begin
			flag_carry <= reg_wdata[rotate_round_pkg::FLAG_C_POS];
		end
	end

	// Overflow: sign change of a step, cleared by set carry
	// Rounding may wrap without marking overflow
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_overflow <= rotate_round_pkg::FLAG_RESET;
		end else if (do_step) begin
			flag_overflow <= step_ovf;
		end else if (take_force) begin
			flag_overflow <= 1'b0;
		end else if (wr_flags) begin
			flag_overflow <= reg_wdata[rotate_round_pkg::FLAG_O_POS];
		end
	end

	// Sign and zero describe the rotate result; rounding leaves them
	// Set carry leaves them as well
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_sign <= rotate_round_pkg::FLAG_RESET;
			flag_zero <= rotate_round_pkg::FLAG_RESET;
		end else if (do_step) begin
			flag_sign <= step_sign;
			flag_zero <= step_zero;
		end else if (wr_flags) begin
			flag_sign <= reg_wdata[rotate_round_pkg::FLAG_S_POS];
			flag_zero <= reg_wdata[rotate_round_pkg::FLAG_Z_POS];
		end
	end

	// Ready drops for multi-cycle work and returns with the finish
	// Registered from next_state so it is a flop yet never a cycle late
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_ready <= 1'b1;
		end else begin
			op_ready <= (next_state == ST_IDLE);
		end
	end

	// Done pulse and code length of the finished instruction
	// Code length is latched at take so software can read it while busy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op_done <= 1'b0;
			op_bytes <= rotate_round_pkg::BYTES_RESET;
		end else begin
			op_done <= finish;
			if (take) begin
				op_bytes <= next_bytes;
			end
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	// Zero between reads keeps stale data off the bus
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule

// file: dv/rotate_round_sva.sv
// Checker for the rotate and round unit instruction and register ports
`timescale 1ns/1ps
module rotate_round_sva #(
	parameter int ACC_W = 24
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire logic [1:0] op_code,
	input wire logic op_has_count,
	input wire logic [3:0] op_count,
	input wire logic [ACC_W-1:0] op_divisor,
	input wire logic op_ready,
	input wire logic op_done,
	input wire logic [2:0] op_bytes,
	input wire logic [3:0] reg_addr,
	input wire logic reg_read,
	input wire logic [ACC_W-1:0] reg_rdata,
	input wire logic flag_carry,
	input wire logic flag_overflow,
	input wire logic flag_sign,
	input wire logic flag_zero
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Instruction accepted at this edge
	wire take = op_valid && op_ready;
	wire rot = take && !op_code[1];
	wire [3:0] flags = {flag_zero, flag_sign, flag_overflow, flag_carry};
	// Code length expected for the instruction being taken
	wire [2:0] exp_bytes = op_code[1] ? (op_code[0] ? 3'h1 : 3'h7) : (op_has_count ? 3'h2 : 3'h1);
	// Steps still due in a counted rotate; the round delay assumes width 24
	logic [3:0] left;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			left <= 4'h0;
		else if (rot && op_has_count)
			left <= op_count;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
	sequence busy_s; !op_ready; endsequence
	sequence finish_s; op_ready && op_done; endsequence
	bytes_len_a: assert property (take |=> op_bytes == $past(exp_bytes))
		else $error("code length wrong");
	single_step_a: assert property (rot && (!op_has_count || op_count == 4'h0) |=> finish_s)
		else $error("single rotate not done in one cycle");
	count_busy_a: assert property (left != 4'h0 |-> busy_s)
		else $error("ready during counted rotate");
	count_end_a: assert property (left == 4'h1 |=> finish_s)
		else $error("counted rotate end late");
	round_time_a: assert property (take && op_code == 2'h2 && op_divisor != '0
		|=> busy_s ##25 busy_s ##1 finish_s)
		else $error("round timing wrong");
	round_flags_a: assert property (take && op_code == 2'h2 |=> $stable(flags) [*8])
		else $error("round changed flags");
	set_carry_a: assert property (take && op_code == 2'h3 |=> (flag_carry && !flag_overflow) and finish_s)
		else $error("set carry flags wrong");
	sign_zero_a: assert property (rot && !op_has_count |=> !(flag_zero && flag_sign))
		else $error("zero and sign both set");
	flag_read_a: assert property (reg_read && reg_addr == 4'h4 && op_ready && !op_valid
		|=> reg_rdata == ACC_W'(flags))
		else $error("flag read wrong");
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
		else $error("read data not zero");
endmodule

bind accumulator_rotate_round_unit rotate_round_sva #(.ACC_W(ACC_W)) i_sva (
	.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
	.op_has_count(op_has_count), .op_count(op_count), .op_divisor(op_divisor),
	.op_ready(op_ready), .op_done(op_done), .op_bytes(op_bytes), .reg_addr(reg_addr),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .flag_carry(flag_carry),
	.flag_overflow(flag_overflow), .flag_sign(flag_sign), .flag_zero(flag_zero)
);

// file: dv/accumulator_rotate_round_unit_tb.sv
// Testbench for the rotate and round unit
`timescale 1ns/1ps
module accumulator_rotate_round_unit_tb;
	localparam int W = 24;
	logic clk, rst_n, op_valid, op_has_count, op_ready, op_done, reg_write, reg_read;
	logic flag_carry, flag_overflow, flag_sign, flag_zero;
	logic [1:0] op_code, op_acc;
	logic [3:0] op_count, reg_addr;
	logic [2:0] op_bytes;
	logic [W-1:0] op_divisor, reg_wdata, reg_rdata, x, e;
	int bad_count, checked;
	// Model flags {Z,S,O,C} and carry with accumulator
	logic [3:0] mf;
	logic [W:0] cv;
	// Rotate cases: left, accumulator, counted, count, start value
	logic rl[5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
	logic [1:0] ta[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
	logic th[5] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0};
	logic [3:0] tn[5] = '{4'h0, 4'h3, 4'hf, 4'h0, 4'h0};
	logic [W-1:0] ti[5] = '{24'h800001, 24'h000005, 24'h123456, 24'h000002, 24'h000001};
	// Round cases: value and half-scale division, edges at half and negative
	logic [W-1:0] rx[5] = '{24'h00002f, 24'h00002c, 24'h00002d, 24'hffffd3, 24'h00002f};
	logic [W-1:0] dv[5] = '{24'h00000a, 24'h00000a, 24'h00000a, 24'h00000a, 24'h000000};

	accumulator_rotate_round_unit #(.ACC_W(W)) i_dut (.clk(clk), .rst_n(rst_n),
		.op_valid(op_valid), .op_code(op_code), .op_acc(op_acc), .op_has_count(op_has_count),
		.op_count(op_count), .op_divisor(op_divisor), .op_ready(op_ready), .op_done(op_done),
		.op_bytes(op_bytes), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .flag_carry(flag_carry),
		.flag_overflow(flag_overflow), .flag_sign(flag_sign), .flag_zero(flag_zero));

	// Free running clock
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [W-1:0] d);
		@(posedge clk);
		reg_write <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [W-1:0] exp);
		@(posedge clk);
		reg_read <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'h0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// One instruction; counts cycles from the take edge to op_done
	task automatic op(input logic [1:0] c, a, input logic h, input logic [3:0] n, input logic [W-1:0] d,
		input int lat);
		int k;
		@(posedge clk);
		op_valid <= 1'h1;
		op_code <= c;
		op_acc <= a;
		op_has_count <= h;
		op_count <= n;
		op_divisor <= d;
		@(posedge clk);
		op_valid <= 1'h0;
		k = 1;
		#1;
		while (op_done !== 1'h1 && k < 60) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk(k, lat);
	endtask

	task automatic set_carry();
		op(2'h3, 2'h0, 1'h0, 4'h0, '0, 1);
		mf = {mf[3:2], 2'h1};
		rd(4'h4, {20'h0, mf});
		rd(4'h5, {17'h0, 3'h1, 4'h0});
	endtask

	task automatic report_and_stop();
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Cut a hang short
	initial begin
		#50000;
		bad_count++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		{rst_n, op_valid, op_has_count, reg_write, reg_read} = '0;
		{op_code, op_acc, op_count, reg_addr, op_divisor, reg_wdata} = '0;
		bad_count = 0;
		checked = 0;
		mf = 4'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		rd(4'h4, '0);
		rd(4'h2, '0);
		rd(4'h9, '0);
		wr(4'h5, 24'h0000ff);
		rd(4'h5, '0);
		// Overflow set beforehand so that set carry must visibly clear it
		wr(4'h4, 24'hfffffe);
		mf = 4'he;
		rd(4'h4, 24'h00000e);
		set_carry();
		// Rotates chain the carry from one case to the next
		for (int i = 0; i < 5; i++) begin
			wr({2'h0, ta[i]}, ti[i]);
			cv = {mf[0], ti[i]};
			x = ti[i];
			for (int s = 0; s < (th[i] ? int'(tn[i]) : 1); s++) begin
				x = cv[W-1:0];
				cv = rl[i] ? {cv[W-1:0], cv[W]} : {cv[0], cv[W:1]};
			end
			if (!th[i] || tn[i] != 4'h0)
				mf = {cv[W-1:0] == '0, cv[W-1], x[W-1] ^ cv[W-1], cv[W]};
			op({1'h0, !rl[i]}, ta[i], th[i], tn[i], '0, th[i] ? tn[i] + 1 : 1);
			rd({2'h0, ta[i]}, cv[W-1:0]);
			rd(4'h4, {20'h0, mf});
			rd(4'h5, {17'h0, th[i] ? 3'h2 : 3'h1, 4'h0});
		end
		set_carry();
		// Rounding on the first accumulator; the accumulator index is ignored
		for (int i = 0; i < 5; i++) begin
			wr(4'h0, rx[i]);
			x = rx[i][W-1] ? -rx[i] : rx[i];
			e = (x / dv[i]) * dv[i] + ((2 * (x % dv[i]) >= dv[i]) ? dv[i] : '0);
			e = dv[i] == '0 ? rx[i] : (rx[i][W-1] ? -e : e);
			op(2'h2, 2'h3, 1'h0, 4'h0, dv[i], dv[i] == '0 ? 1 : W + 3);
			rd(4'h0, e);
			rd(4'h4, {20'h0, mf});
			rd(4'h5, {17'h0, 3'h7, 4'h0});
		end
		report_and_stop();
	end
endmodule
